// ### parallel_printer_port.sv
// Parallel printer port with APB register access
`timescale 1ns/1ps
`default_nettype none
module parallel_printer_port (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [printer_port_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] print_data,
  output logic strobe_n,
  output logic auto_feed_n,
  output logic init_n,
  output logic select_in_n,
  input wire logic ack_n,
  input wire logic busy,
  input wire logic paper_end,
  input wire logic selected,
  input wire logic error_n,
  output logic adapter_power,
  output logic port_primary,
  output logic irq_req7,
  output logic irq
);

  logic [7:0] sys_reg;
  logic [7:0] data_reg;
  logic [printer_port_pkg::CTL_W-1:0] ctl_reg;
  logic irq_flag;
  logic [printer_port_pkg::EVT_W-1:0] evt_status;
  logic [printer_port_pkg::EVT_W-1:0] evt_mask;
  logic [printer_port_pkg::PIN_W-1:0] pins_s;
  logic ack_prev;
  logic err_prev;
  logic [7:0] rd_byte;

  // Printer inputs cross into ref_clk before anything looks at them
  pin_sync #(
    .WIDTH(printer_port_pkg::PIN_W),
    .IDLE(printer_port_pkg::PIN_IDLE)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pins({ack_n, busy, paper_end, selected, error_n}),
    .pins_sync(pins_s)
  );

  // Bus decode; the slave never inserts wait states
  wire [printer_port_pkg::IDX_W-1:0] idx = paddr[printer_port_pkg::ADDR_W-1:2];
  wire aligned = (paddr[1:0] == 2'h0);
  wire hit_sys = aligned && (idx == printer_port_pkg::IDX_SYSTEM);
  wire hit_data = aligned && (idx == printer_port_pkg::IDX_DATA);
  wire hit_status = aligned && (idx == printer_port_pkg::IDX_STATUS);
  wire hit_ctl = aligned && (idx == printer_port_pkg::IDX_CONTROL);
  wire hit_evt = aligned && (idx == printer_port_pkg::IDX_EVT_STATUS);
  wire hit_mask = aligned && (idx == printer_port_pkg::IDX_EVT_MASK);
  wire mapped = hit_sys | hit_data | hit_status | hit_ctl | hit_evt | hit_mask;
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr_ok = access && pwrite && mapped && pstrb[0];
  wire rd_setup = setup && !pwrite;
  wire status_rd_done = access && !pwrite && hit_status;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // Synchronised pin levels and their falling edges
  wire ack_s = pins_s[printer_port_pkg::PIN_ACK];
  wire busy_s = pins_s[printer_port_pkg::PIN_BUSY];
  wire err_s = pins_s[printer_port_pkg::PIN_ERROR];
  wire ack_fall = ack_prev && !ack_s;
  wire err_fall = err_prev && !err_s;
  wire irq_en = ctl_reg[printer_port_pkg::CTL_IRQ_EN];

  // Status word as software sees it; low two bits stay zero
  logic [7:0] status_word;
  always_comb begin
    status_word = 8'h00;
    status_word[printer_port_pkg::STS_BUSY] = !busy_s;
    status_word[printer_port_pkg::STS_ACK] = ack_s;
    status_word[printer_port_pkg::STS_PAPER] =
      pins_s[printer_port_pkg::PIN_PAPER];
    status_word[printer_port_pkg::STS_SELECT] =
      pins_s[printer_port_pkg::PIN_SELECT];
    status_word[printer_port_pkg::STS_ERROR] = err_s;
    status_word[printer_port_pkg::STS_IRQ] = irq_flag;
  end

  // Read mux; control returns stored bits, not the inverted pins
  wire [7:0] next_rd_byte =
    hit_sys ? sys_reg :
    hit_data ? data_reg :
    hit_status ? status_word :
    hit_ctl ? {3'h0, ctl_reg} :
    hit_evt ? {6'h00, evt_status} :
    hit_mask ? {6'h00, evt_mask} : 8'h00;

  // Interrupt flag: set beats the clear, and the read clears only what
  // it actually returned, so an acknowledge during the read survives
  wire flag_set = ack_fall && irq_en;
  wire flag_clr = status_rd_done && rd_byte[printer_port_pkg::STS_IRQ];
  wire next_irq_flag = flag_set || (irq_flag && !flag_clr);

  // Sticky events, write one to clear, set wins
  wire [printer_port_pkg::EVT_W-1:0] evt_set = {err_fall, ack_fall};
  wire [printer_port_pkg::EVT_W-1:0] evt_clr =
    (wr_ok && hit_evt) ? pwdata[printer_port_pkg::EVT_W-1:0] : '0;
  wire [printer_port_pkg::EVT_W-1:0] next_evt_status =
    evt_set | (evt_status & ~evt_clr);

  // Read data is captured in the setup phase, ready for the access phase
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_byte <= 8'h00;
    end else if (rd_setup) begin
      rd_byte <= next_rd_byte;
    end
  end
  assign prdata = {24'h000000, rd_byte};

  // Software-written registers; whole system byte is stored so the
  // bits owned by others read back as written
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_reg <= printer_port_pkg::SYS_RESET;
      data_reg <= printer_port_pkg::DATA_RESET;
      ctl_reg <= printer_port_pkg::CTL_RESET;
      evt_mask <= printer_port_pkg::EVT_RESET;
    end else if (wr_ok) begin
      if (hit_sys) sys_reg <= pwdata[7:0];
      if (hit_data) data_reg <= pwdata[7:0];
      if (hit_ctl)
        ctl_reg <= pwdata[printer_port_pkg::CTL_W-1:0];
      if (hit_mask) evt_mask <= pwdata[printer_port_pkg::EVT_W-1:0];
    end
  end

  // Flags and edge history
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_flag <= 1'b0;
      evt_status <= printer_port_pkg::EVT_RESET;
      ack_prev <= 1'b1;
      err_prev <= 1'b1;
    end else begin
      irq_flag <= next_irq_flag;
      evt_status <= next_evt_status;
      ack_prev <= ack_s;
      err_prev <= err_s;
    end
  end

  // Connector outputs; strobe, feed and select-in are active low pins
  assign print_data = data_reg;
  assign strobe_n = !ctl_reg[printer_port_pkg::CTL_STROBE];
  assign auto_feed_n =
    !ctl_reg[printer_port_pkg::CTL_AUTO_FEED];
  assign select_in_n =
    !ctl_reg[printer_port_pkg::CTL_SELECT_IN];
  // Initialize follows its bit; software must time the low pulse itself
  assign init_n = ctl_reg[printer_port_pkg::CTL_INIT];

  // System bits; power reaches the serial side through adapter_power
  assign adapter_power = sys_reg[printer_port_pkg::SYS_POWER];
  assign port_primary = sys_reg[printer_port_pkg::SYS_PRIMARY];

  // Interrupt outputs
  assign irq_req7 = irq_flag && irq_en;
  assign irq = |(evt_status & evt_mask);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence wr_s(logic hit);
    setup && pwrite && hit ##1 access && pstrb[0];
  endsequence

  sequence status_read_s;
    setup && !pwrite && hit_status ##1 access;
  endsequence

  data_pins_a: assert property (
    wr_s(hit_data) |=> print_data == $past(pwdata[7:0]))
    else $error("data pins do not follow data write");

  power_bit_a: assert property (
    wr_s(hit_sys) |=>
      adapter_power == $past(pwdata[printer_port_pkg::SYS_POWER]))
    else $error("power bit does not follow system write");

  primary_bit_a: assert property (
    wr_s(hit_sys) |=>
      port_primary == $past(pwdata[printer_port_pkg::SYS_PRIMARY]))
    else $error("primary bit does not follow system write");

  ctl_pins_a: assert property (
    wr_s(hit_ctl) |=>
      strobe_n == !$past(pwdata[printer_port_pkg::CTL_STROBE])
      && auto_feed_n == !$past(pwdata[printer_port_pkg::CTL_AUTO_FEED])
      && init_n == $past(pwdata[printer_port_pkg::CTL_INIT])
      && select_in_n == !$past(pwdata[printer_port_pkg::CTL_SELECT_IN]))
    else $error("control pins wrong after control write");

  ctl_read_a: assert property (
    setup && !pwrite && hit_ctl |=> prdata[7:0] == {3'h0, ctl_reg})
    else $error("control read does not return stored bits");

  busy_inv_a: assert property (
    setup && !pwrite && hit_status |=>
      prdata[printer_port_pkg::STS_BUSY] == !$past(busy_s))
    else $error("status busy bit not inverted");

  status_bits_a: assert property (
    setup && !pwrite && hit_status |=>
      prdata[printer_port_pkg::STS_ACK] == $past(ack_s)
      && prdata[printer_port_pkg::STS_ERROR] == $past(err_s)
      && prdata[printer_port_pkg::STS_IRQ-1:0] == 2'h0)
    else $error("status layout wrong");

  flag_set_a: assert property (
    ack_fall && irq_en |=> irq_flag ##0 irq_req7 || !irq_en)
    else $error("acknowledge did not set interrupt flag");

  // A flag set during the read is not in the returned byte, so it stays
  flag_clear_a: assert property (
    !flag_set ##0 status_read_s ##0 !flag_set |=> !irq_flag)
    else $error("status read did not clear interrupt flag");

  irq_gate_a: assert property (
    !irq_en |-> !irq_req7 ##1 (!irq_flag || $past(irq_flag)))
    else $error("printer interrupt raised while disabled");

  reset_pins_a: assert property (@(posedge ref_clk)
    disable iff (1'b0) !reset_n |-> strobe_n && !irq_req7)
    else $error("strobe or interrupt active during reset");

  // Event bits: set wins, write one clears, mask gates the output
  evt_set_a: assert property (
    ack_fall |=> evt_status[printer_port_pkg::EVT_ACK])
    else $error("acknowledge edge did not set its event bit");

  evt_clear_a: assert property (
    wr_ok && hit_evt && pwdata[printer_port_pkg::EVT_ACK] && !ack_fall
      |=> !evt_status[printer_port_pkg::EVT_ACK])
    else $error("write one did not clear acknowledge event");

  evt_irq_a: assert property (
    evt_status[printer_port_pkg::EVT_ERROR]
      && evt_mask[printer_port_pkg::EVT_ERROR] |-> irq)
    else $error("unmasked error event gives no interrupt");

  // Refused transfers: unmapped space errors, no write without strobe
  bad_addr_a: assert property (
    access && idx > printer_port_pkg::IDX_EVT_MASK |-> pslverr)
    else $error("unmapped access gave no error response");

  write_refused_a: assert property (
    access && pwrite && !(mapped && pstrb[0]) |=>
      $stable(sys_reg) && $stable(data_reg) && $stable(ctl_reg)
      && $stable(evt_mask))
    else $error("refused write changed a register");

endmodule // parallel_printer_port
`default_nettype wire

// ### pin_sync.sv
// Two-stage synchroniser for the printer status inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = printer_port_pkg::PIN_W,
  parameter logic [WIDTH-1:0] IDLE = printer_port_pkg::PIN_IDLE
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] pins_sync
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second; reset to idle levels avoids a
  // false edge right after reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= IDLE;
      pins_sync <= IDLE;
    end else begin
      meta <= pins;
      pins_sync <= meta;
    end
  end

endmodule // pin_sync
`default_nettype wire

// ### printer_model.sv
// Behavioural printer on the far side of the parallel port
`timescale 1ns/1ps
`default_nettype none
module printer_model #(
  parameter int ACK_LEN = 100
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] print_data,
  input wire logic strobe_n,
  output logic ack_n,
  output logic busy,
  output logic [7:0] captured
);
  int cnt;
  // Busy from strobe until the ack pulse ends; 100 cycles is 5 us
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_n <= 1'b1;
      busy <= 1'b0;
      captured <= 8'h00;
      cnt <= 0;
    end else if (cnt == 0) begin
      if (!strobe_n) begin
        captured <= print_data;
        busy <= 1'b1;
        cnt <= 1;
      end
    end else begin
      cnt <= cnt + 1;
      ack_n <= !(cnt >= 20 && cnt < 20 + ACK_LEN);
      if (cnt == 20 + ACK_LEN) begin
        busy <= 1'b0;
        cnt <= 0;
      end
    end
  end
endmodule // printer_model
`default_nettype wire

// ### printer_port_pkg.sv
// Constants shared by the parallel printer port and its input synchroniser
package printer_port_pkg;

  // Register indices; the byte address is four times the index
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_SYSTEM = 10'h07c;
  localparam logic [IDX_W-1:0] IDX_DATA = 10'h378;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h379;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 10'h37a;
  localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 10'h380;
  localparam logic [IDX_W-1:0] IDX_EVT_MASK = 10'h381;
  localparam int ADDR_W = IDX_W + 2;

  // Shared system register fields
  localparam int SYS_POWER = 2;
  localparam int SYS_PRIMARY = 0;
  localparam logic [7:0] SYS_RESET = 8'h00;

  // Status register fields
  localparam int STS_BUSY = 7;
  localparam int STS_ACK = 6;
  localparam int STS_PAPER = 5;
  localparam int STS_SELECT = 4;
  localparam int STS_ERROR = 3;
  localparam int STS_IRQ = 2;

  // Control register fields
  localparam int CTL_W = 5;
  localparam int CTL_IRQ_EN = 4;
  localparam int CTL_SELECT_IN = 3;
  localparam int CTL_INIT = 2;
  localparam int CTL_AUTO_FEED = 1;
  localparam int CTL_STROBE = 0;
  localparam logic [CTL_W-1:0] CTL_RESET = 5'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Own event register: sticky bits, write one to clear
  localparam int EVT_W = 2;
  localparam int EVT_ACK = 0;
  localparam int EVT_ERROR = 1;
  localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

  // Synchronised printer inputs: ack_n, busy, paper, select, error_n
  localparam int PIN_W = 5;
  localparam int PIN_ACK = 4;
  localparam int PIN_BUSY = 3;
  localparam int PIN_PAPER = 2;
  localparam int PIN_SELECT = 1;
  localparam int PIN_ERROR = 0;
  localparam logic [PIN_W-1:0] PIN_IDLE = 5'h11;

endpackage

// ### test_parallel_printer_port.sv
// Self-checking bench for the parallel printer port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, g) begin samples_checked++; if ((g) !== (x)) begin \
  mismatches++; $display("mismatch %s exp %h got %h", n, x, g); end end
module test_parallel_printer_port;
  logic ref_clk = 1'b0, reset_n, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, paper_end = 1'b0, selected = 1'b1, error_n = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, e, strobe_n, auto_feed_n, init_n, select_in_n;
  logic ack_n, busy, adapter_power, port_primary, irq_req7, irq;
  logic [7:0] print_data, captured;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  parallel_printer_port u_parallel_printer_port (.ref_clk(ref_clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .print_data(print_data),
    .strobe_n(strobe_n), .auto_feed_n(auto_feed_n), .init_n(init_n),
    .select_in_n(select_in_n), .ack_n(ack_n), .busy(busy),
    .paper_end(paper_end), .selected(selected), .error_n(error_n),
    .adapter_power(adapter_power), .port_primary(port_primary),
    .irq_req7(irq_req7), .irq(irq));
  printer_model u_printer_model (.ref_clk(ref_clk), .reset_n(reset_n),
    .print_data(print_data), .strobe_n(strobe_n), .ack_n(ack_n),
    .busy(busy), .captured(captured));
  initial forever #25 ref_clk = ~ref_clk;
  // Cut a hang short well past the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  task results;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer; returns at the next falling edge so outputs settle
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk) penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge ref_clk);
  endtask
  task wr(input logic [9:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask
  task rd(input logic [9:0] i, input logic [7:0] x);
    apb(1'b0, {i, 2'b00}, 8'h00);
    `CHK("read", {24'h0, x}, r)
  endtask
  task t_regs;
    `CHK("strobe", 1'b1, strobe_n)
    `CHK("pins", 4'b1100,
      {auto_feed_n, select_in_n, init_n, irq_req7})
    rd(printer_port_pkg::IDX_CONTROL, 8'h00);
    wr(printer_port_pkg::IDX_SYSTEM, 8'h05);
    `CHK("sys", 2'b11, {adapter_power, port_primary})
    rd(printer_port_pkg::IDX_SYSTEM, 8'h05);
    wr(printer_port_pkg::IDX_SYSTEM, r[7:0] & 8'hfe);
    `CHK("sec", 2'b10, {adapter_power, port_primary})
    wr(printer_port_pkg::IDX_DATA, 8'ha5);
    `CHK("data", 8'ha5, print_data)
    rd(printer_port_pkg::IDX_DATA, 8'ha5);
    // A write with the low byte strobe off must not land
    @(posedge ref_clk) pstrb <= 4'he;
    wr(printer_port_pkg::IDX_DATA, 8'h5a);
    @(posedge ref_clk) pstrb <= 4'hf;
    rd(printer_port_pkg::IDX_DATA, 8'ha5);
    // Initialize has been low since reset; keep it low past 50 us
    repeat (1100) @(negedge ref_clk);
    wr(printer_port_pkg::IDX_CONTROL, 8'h0f);
    `CHK("ctl", 4'b0100,
      {select_in_n, init_n, auto_feed_n, strobe_n})
    rd(printer_port_pkg::IDX_CONTROL, 8'h0f);
    apb(1'b0, 12'hf00, 8'h00);
    `CHK("bad", 33'h100000000, {e, r})
    // Release strobe and let the printer finish the byte it took, so
    // the next test starts with an idle printer
    wr(printer_port_pkg::IDX_CONTROL, 8'h04);
    `CHK("ctl idle", 4'b1111,
      {select_in_n, init_n, auto_feed_n, strobe_n})
    repeat (400) if (busy !== 1'b0) @(negedge ref_clk);
    repeat (4) @(negedge ref_clk);
    `CHK("first byte", 8'ha5, captured)
    $display("test regs done");
  endtask
  // Print one byte; interrupt enable in bit 4 per call
  task print(input logic [7:0] d, input logic en);
    wr(printer_port_pkg::IDX_DATA, d);
    wr(printer_port_pkg::IDX_CONTROL, {3'h0, en, 4'h5});
    wr(printer_port_pkg::IDX_CONTROL, {3'h0, en, 4'h4});
  endtask
  task t_irq;
    wr(printer_port_pkg::IDX_EVT_STATUS, 8'h03);
    wr(printer_port_pkg::IDX_EVT_MASK, 8'h01);
    print(8'h3c, 1'b1);
    rd(printer_port_pkg::IDX_STATUS, 8'h58);
    repeat (400) if (irq_req7 !== 1'b1) @(negedge ref_clk);
    `CHK("irq7", 2'b11, {irq_req7, irq})
    repeat (400) if (busy !== 1'b0) @(negedge ref_clk);
    repeat (4) @(negedge ref_clk);
    rd(printer_port_pkg::IDX_STATUS, 8'hdc);
    rd(printer_port_pkg::IDX_STATUS, 8'hd8);
    `CHK("irq7 off", 1'b0, irq_req7)
    `CHK("byte", 8'h3c, captured)
    $display("test irq done");
  endtask
  task t_quiet;
    wr(printer_port_pkg::IDX_EVT_STATUS, 8'h01);
    `CHK("irq clr", 1'b0, irq)
    @(posedge ref_clk) paper_end <= 1'b1;
    selected <= 1'b0;
    print(8'hc3, 1'b0);
    repeat (400) if (busy !== 1'b0) @(negedge ref_clk);
    repeat (4) @(negedge ref_clk);
    `CHK("irq7 dis", 2'b01, {irq_req7, irq})
    rd(printer_port_pkg::IDX_STATUS, 8'he8);
    rd(printer_port_pkg::IDX_EVT_STATUS, 8'h01);
    wr(printer_port_pkg::IDX_EVT_MASK, 8'h00);
    @(posedge ref_clk) error_n <= 1'b0;
    repeat (4) @(negedge ref_clk);
    wr(printer_port_pkg::IDX_EVT_STATUS, 8'h01);
    `CHK("masked", 1'b0, irq)
    rd(printer_port_pkg::IDX_EVT_STATUS, 8'h02);
    wr(printer_port_pkg::IDX_EVT_MASK, 8'h02);
    `CHK("unmask", 1'b1, irq)
    wr(printer_port_pkg::IDX_EVT_STATUS, 8'h02);
    `CHK("w1c", 1'b0, irq)
    rd(printer_port_pkg::IDX_STATUS, 8'he0);
    $display("test quiet done");
  endtask
  // Reset is driven from unknown to low so the asynchronous branches run
  initial begin
    reset_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    t_regs();
    t_irq();
    t_quiet();
    results();
  end
endmodule // test_parallel_printer_port
`default_nettype wire
